// ### hw/irq_seq_pkg.sv
package irq_seq_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0]  ADDR_PEND   = 8'h00;
   localparam logic [7:0]  ADDR_LEVEL  = 8'h04;
   localparam logic [7:0]  ADDR_TBASE  = 8'h08;
   localparam logic [7:0]  ADDR_STAT   = 8'h0C;
   localparam logic [7:0]  ADDR_MASK   = 8'h10;
   localparam logic [7:0]  ADDR_STATE  = 8'h14;

   // ****************************************************************
   // Reset values and fields
   // ****************************************************************
   localparam logic [31:0] TBASE_RST   = 32'h0000_0000;
   localparam logic        STACK_RST   = 1'h0;
   localparam int          LVL_W       = 3;
   localparam int          STAT_W      = 4;
   localparam int          STAT_ACC    = 0;
   localparam int          STAT_SWI    = 1;
   localparam int          STAT_BRKF   = 2;
   localparam int          STAT_RET    = 3;
   localparam logic [7:0]  SWI_LOW_MAX = 8'h7F;
   localparam logic [7:0]  BRK_ALL_ONE = 8'hFF;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // ****************************************************************
   // Sequencer states and accepted kinds
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_FETCH = 3'b010,
      ST_JUMP  = 3'b100
   } seq_e;

   typedef enum logic [1:0] {
      K_WDT = 2'h0,
      K_SW  = 2'h1,
      K_PER = 2'h2
   } kind_e;

endpackage : irq_seq_pkg

// ### hw/interrupt_request_sequencer.sv
// Function
// - Software interrupts 0..127 save the stack-select flag, then clear it to use INTERRUPT_STACK_POINTER.
// - Return from a low-range software interrupt restores the saved stack-select flag.
// - Software interrupts 128..255 leave the stack-select flag untouched.
// - Vectors are four bytes; acceptance jumps to the address read from the vector.
// - Break with byte FFh at FFFFFE7h vectors through relocatable entry zero.
// - A source request sets its pending flag, held until acceptance or a software zero write.
// - Acceptance and the vector jump clear the pending flag automatically.
// - Software writing zero to a pending flag clears it.
// - Each peripheral source has a programmable three-bit request level.
// - Among equal-level pending requests, the higher fixed hardware priority wins.
// - Reset and watchdog priorities are fixed; reset ranks above everything.
`timescale 1ns/1ns
module interrupt_request_sequencer #(
   parameter int          NSRC    = 8,
   parameter logic [7:0]  PER_NUM = 8'h10,
   parameter logic [31:0] WDT_VEC = 32'h0FFF_FFF0,
   parameter logic [31:0] BRK_VEC = 32'h0FFF_FFE4
) (
   // Clock and reset
   input  wire logic                CLK,
   input  wire logic                RST,
   // Request sources
   input  wire logic [NSRC-1:0]     SRC_REQ,
   input  wire logic                WDT_REQ,
   // CPU side
   input  wire logic                SWI_REQ,
   input  wire logic [7:0]          SWI_NUM,
   input  wire logic                BRK_EXEC,
   input  wire logic [7:0]          BRK_BYTE,
   input  wire logic                CPU_RET,
   input  wire logic [2:0]          CPU_IPL,
   input  wire logic                CPU_IEN,
   output logic                     VEC_RD,
   output logic [31:0]              VEC_ADDR,
   input  wire logic                VEC_VALID,
   input  wire logic [31:0]         VEC_DATA,
   output logic                     JUMP,
   output logic [31:0]              JUMP_ADDR,
   output logic                     STACK_SEL,
   output logic                     BUSY,
   output logic                     IRQ,
   // AXI4-Lite slave
   input  wire logic [7:0]          AWADDR,
   input  wire logic                AWVALID,
   output logic                     AWREADY,
   input  wire logic [31:0]         WDATA,
   input  wire logic [3:0]          WSTRB,
   input  wire logic                WVALID,
   output logic                     WREADY,
   output logic [1:0]               BRESP,
   output logic                     BVALID,
   input  wire logic                BREADY,
   input  wire logic [7:0]          ARADDR,
   input  wire logic                ARVALID,
   output logic                     ARREADY,
   output logic [31:0]              RDATA,
   output logic [1:0]               RRESP,
   output logic                     RVALID,
   input  wire logic                RREADY
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      irq_seq_pkg::seq_e                   st;
      irq_seq_pkg::kind_e                  kind;
      logic [7:0]                          cur;
      logic [NSRC-1:0]                     pend;
      logic                                wdt_pend;
      logic [NSRC*irq_seq_pkg::LVL_W-1:0]  lvl;
      logic [31:0]                         tbase;
      logic [irq_seq_pkg::STAT_W-1:0]      stat;
      logic [irq_seq_pkg::STAT_W-1:0]      mask;
      logic                                stack_sel;
      logic                                saved;
      logic                                saved_ok;
      logic                                vec_rd;
      logic [31:0]                         vec_addr;
      logic                                jump;
      logic [31:0]                         jump_addr;
      logic                                busy;
      logic                                irq;
      logic                                awready;
      logic                                aw_have;
      logic [7:0]                          aw_addr;
      logic                                wready;
      logic                                w_have;
      logic [31:0]                         w_data;
      logic [3:0]                          w_strb;
      logic                                bvalid;
      logic [1:0]                          bresp;
      logic                                arready;
      logic                                rvalid;
      logic [31:0]                         rdata;
      logic [1:0]                          rresp;
   } state_s;

   state_s                          q;
   state_s                          d;
   logic                            per_ok;
   logic [7:0]                      per_idx;
   logic                            tie_ok;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [2:0] lvl_of(input logic [NSRC*irq_seq_pkg::LVL_W-1:0] l,
                                         input int i);
      lvl_of = l[i*irq_seq_pkg::LVL_W +: irq_seq_pkg::LVL_W];
   endfunction : lvl_of

   function automatic logic [31:0] vec_of(input logic [31:0] base, input logic [7:0] n);
      vec_of = base + {22'h0, n, 2'h0};
   endfunction : vec_of

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == irq_seq_pkg::ADDR_PEND) || (a == irq_seq_pkg::ADDR_LEVEL) ||
               (a == irq_seq_pkg::ADDR_TBASE) || (a == irq_seq_pkg::ADDR_STAT) ||
               (a == irq_seq_pkg::ADDR_MASK) || (a == irq_seq_pkg::ADDR_STATE);
   endfunction : mapped

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb
   begin
      logic [31:0]                    bm;
      logic [31:0]                    wv;
      logic [NSRC-1:0]                sw_clr;
      logic [NSRC-1:0]                acc_clr;
      logic [irq_seq_pkg::STAT_W-1:0] ev;
      logic [irq_seq_pkg::STAT_W-1:0] w1c;
      logic [2:0]                     best;
      bm      = {{8{q.w_strb[3]}}, {8{q.w_strb[2]}}, {8{q.w_strb[1]}}, {8{q.w_strb[0]}}};
      wv      = q.w_data;
      sw_clr  = '0;
      acc_clr = '0;
      ev      = '0;
      w1c     = '0;
      best    = '0;
      per_ok  = 1'b0;
      per_idx = '0;
      tie_ok  = 1'b1;
      d       = q;
      // Eligible peripheral with the highest level; lower index wins ties.
      for (int i = 0; i < NSRC; i++)
      begin
         if (q.pend[i] && CPU_IEN && (lvl_of(q.lvl, i) > CPU_IPL) &&
             (!per_ok || lvl_of(q.lvl, i) > best))
         begin
            per_ok  = 1'b1;
            per_idx = 8'(i);
            best    = lvl_of(q.lvl, i);
         end
      end
      for (int i = 0; i < NSRC; i++)
      begin
         if (q.pend[i] && CPU_IEN && lvl_of(q.lvl, i) == best && 8'(i) < per_idx)
         begin
            tie_ok = 1'b0;
         end
      end
      // AXI write channels are taken independently, then applied together.
      if (AWVALID && q.awready)
      begin
         d.aw_have = 1'b1;
         d.aw_addr = AWADDR;
         d.awready = 1'b0;
      end
      if (WVALID && q.wready)
      begin
         d.w_have = 1'b1;
         d.w_data = WDATA;
         d.w_strb = WSTRB;
         d.wready = 1'b0;
      end
      if (q.aw_have && q.w_have && !q.bvalid)
      begin
         d.aw_have = 1'b0;
         d.w_have  = 1'b0;
         d.bvalid  = 1'b1;
         d.bresp   = mapped(q.aw_addr) ? irq_seq_pkg::RESP_OKAY : irq_seq_pkg::RESP_SLVERR;
         case (q.aw_addr)
            irq_seq_pkg::ADDR_PEND:  sw_clr = bm[NSRC-1:0] & ~wv[NSRC-1:0];
            irq_seq_pkg::ADDR_LEVEL: d.lvl = (q.lvl & ~bm[NSRC*3-1:0]) |
                                             (wv[NSRC*3-1:0] & bm[NSRC*3-1:0]);
            irq_seq_pkg::ADDR_TBASE: d.tbase = (q.tbase & ~bm) | (wv & bm);
            irq_seq_pkg::ADDR_STAT:  w1c = bm[3:0] & wv[3:0];
            irq_seq_pkg::ADDR_MASK:  d.mask = (q.mask & ~bm[3:0]) | (wv[3:0] & bm[3:0]);
            irq_seq_pkg::ADDR_STATE: d.stack_sel = bm[0] ? wv[0] : q.stack_sel;
            default: ;
         endcase
      end
      if (q.bvalid && BREADY)
      begin
         d.bvalid  = 1'b0;
         d.awready = 1'b1;
         d.wready  = 1'b1;
      end
      if (ARVALID && q.arready)
      begin
         d.arready = 1'b0;
         d.rvalid  = 1'b1;
         d.rresp   = mapped(ARADDR) ? irq_seq_pkg::RESP_OKAY : irq_seq_pkg::RESP_SLVERR;
         case (ARADDR)
            irq_seq_pkg::ADDR_PEND:  d.rdata = 32'(q.pend);
            irq_seq_pkg::ADDR_LEVEL: d.rdata = 32'(q.lvl);
            irq_seq_pkg::ADDR_TBASE: d.rdata = q.tbase;
            irq_seq_pkg::ADDR_STAT:  d.rdata = 32'(q.stat);
            irq_seq_pkg::ADDR_MASK:  d.rdata = 32'(q.mask);
            irq_seq_pkg::ADDR_STATE: d.rdata = {16'h0, q.cur, 5'h0, q.busy, q.saved_ok,
                                                q.stack_sel};
            default:                 d.rdata = 32'h0000_0000;
         endcase
      end
      if (q.rvalid && RREADY)
      begin
         d.rvalid  = 1'b0;
         d.arready = 1'b1;
      end
      // Sequencer. Software and break requests are ignored while busy.
      case (q.st)
         irq_seq_pkg::ST_IDLE:
         begin
            if (q.wdt_pend)
            begin
               d.st       = irq_seq_pkg::ST_FETCH;
               d.kind     = irq_seq_pkg::K_WDT;
               d.vec_rd   = 1'b1;
               d.vec_addr = WDT_VEC;
            end
            else if (SWI_REQ)
            begin
               d.st       = irq_seq_pkg::ST_FETCH;
               d.kind     = irq_seq_pkg::K_SW;
               d.cur      = SWI_NUM;
               d.vec_rd   = 1'b1;
               d.vec_addr = vec_of(q.tbase, SWI_NUM);
               ev[irq_seq_pkg::STAT_SWI] = 1'b1;
               if (SWI_NUM <= irq_seq_pkg::SWI_LOW_MAX)
               begin
                  d.saved     = q.stack_sel;
                  d.saved_ok  = 1'b1;
                  d.stack_sel = 1'b0;
               end
            end
            else if (BRK_EXEC)
            begin
               d.st       = irq_seq_pkg::ST_FETCH;
               d.kind     = irq_seq_pkg::K_SW;
               d.cur      = 8'h00;
               d.vec_rd   = 1'b1;
               d.vec_addr = BRK_VEC;
               if (BRK_BYTE == irq_seq_pkg::BRK_ALL_ONE)
               begin
                  d.vec_addr = vec_of(q.tbase, 8'h00);
                  ev[irq_seq_pkg::STAT_BRKF] = 1'b1;
               end
            end
            else if (per_ok)
            begin
               d.st       = irq_seq_pkg::ST_FETCH;
               d.kind     = irq_seq_pkg::K_PER;
               d.cur      = per_idx;
               d.vec_rd   = 1'b1;
               d.vec_addr = vec_of(q.tbase, PER_NUM + per_idx);
            end
         end
         irq_seq_pkg::ST_FETCH:
         begin
            if (VEC_VALID)
            begin
               d.st        = irq_seq_pkg::ST_JUMP;
               d.vec_rd    = 1'b0;
               d.jump      = 1'b1;
               d.jump_addr = VEC_DATA;
               ev[irq_seq_pkg::STAT_ACC] = 1'b1;
               if (q.kind == irq_seq_pkg::K_PER)
               begin
                  acc_clr[q.cur[$clog2(NSRC)-1:0]] = 1'b1;
               end
               if (q.kind == irq_seq_pkg::K_WDT)
               begin
                  d.wdt_pend = 1'b0;
               end
            end
         end
         irq_seq_pkg::ST_JUMP:
         begin
            d.st   = irq_seq_pkg::ST_IDLE;
            d.jump = 1'b0;
         end
         default:
         begin
            d.st     = irq_seq_pkg::ST_IDLE;
            d.vec_rd = 1'b0;
            d.jump   = 1'b0;
         end
      endcase
      if (CPU_RET && q.saved_ok)
      begin
         d.stack_sel = q.saved;
         d.saved_ok  = 1'b0;
         ev[irq_seq_pkg::STAT_RET] = 1'b1;
      end
      // A request arriving in a clearing cycle wins over the clear.
      d.pend     = (q.pend & ~sw_clr & ~acc_clr) | SRC_REQ;
      d.wdt_pend = d.wdt_pend | WDT_REQ;
      d.stat     = (q.stat & ~w1c) | ev;
      d.busy     = (d.st != irq_seq_pkg::ST_IDLE);
      d.irq      = |(d.stat & d.mask);
   end

   // Reset clears everything first, so it outranks every source.
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         q           <= '0;
         q.st        <= irq_seq_pkg::ST_IDLE;
         q.tbase     <= irq_seq_pkg::TBASE_RST;
         q.stack_sel <= irq_seq_pkg::STACK_RST;
         q.awready   <= 1'b1;
         q.wready    <= 1'b1;
         q.arready   <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   assign VEC_RD    = q.vec_rd;
   assign VEC_ADDR  = q.vec_addr;
   assign JUMP      = q.jump;
   assign JUMP_ADDR = q.jump_addr;
   assign STACK_SEL = q.stack_sel;
   assign BUSY      = q.busy;
   assign IRQ       = q.irq;
   assign AWREADY   = q.awready;
   assign WREADY    = q.wready;
   assign BVALID    = q.bvalid;
   assign BRESP     = q.bresp;
   assign ARREADY   = q.arready;
   assign RVALID    = q.rvalid;
   assign RDATA     = q.rdata;
   assign RRESP     = q.rresp;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   sequence s_idle_free;
      q.st == irq_seq_pkg::ST_IDLE && !q.wdt_pend;
   endsequence
   sequence s_swi_low;
      s_idle_free ##0 SWI_REQ && SWI_NUM <= irq_seq_pkg::SWI_LOW_MAX;
   endsequence
   sequence s_swi_high;
      s_idle_free ##0 SWI_REQ && SWI_NUM > irq_seq_pkg::SWI_LOW_MAX && !CPU_RET;
   endsequence
   sequence s_per_take;
      s_idle_free ##0 !SWI_REQ && !BRK_EXEC && per_ok;
   endsequence

   AST_SWI_LOW_ISP: assert property (s_swi_low ##0 !CPU_RET |=> !STACK_SEL && q.saved_ok)
      else $error("low software interrupt did not select the interrupt stack");
   AST_SWI_RESTORE: assert property (CPU_RET && q.saved_ok |=> STACK_SEL == $past(q.saved))
      else $error("stack select not restored on return");
   AST_SWI_HIGH_KEEP: assert property (s_swi_high |=> $stable(STACK_SEL))
      else $error("high software interrupt changed stack select");
   AST_VEC_JUMP: assert property (VEC_RD && VEC_VALID |=> JUMP && JUMP_ADDR == $past(VEC_DATA)
                                  ##1 !JUMP)
      else $error("jump address differs from vector contents");
   AST_BRK_FALLBACK: assert property (s_idle_free ##0 !SWI_REQ && BRK_EXEC && BRK_BYTE == 8'hFF
                                      |=> VEC_RD && VEC_ADDR == q.tbase)
      else $error("break fallback did not use relocatable entry zero");
   AST_PEND_SET: assert property (SRC_REQ[0] |=> q.pend[0])
      else $error("source request did not set pending flag");
   AST_PEND_HOLD: assert property (q.pend[0] && q.st == irq_seq_pkg::ST_IDLE && !q.aw_have
                                   |=> q.pend[0])
      else $error("pending flag dropped before acceptance");
   AST_PEND_AUTOCLR: assert property (VEC_RD && VEC_VALID && q.kind == irq_seq_pkg::K_PER
                                      && q.cur == 8'h00 && !SRC_REQ[0] |=> !q.pend[0])
      else $error("pending flag not cleared on jump");
   AST_SW_CLEAR: assert property (q.aw_have && q.w_have && !q.bvalid
                                  && q.aw_addr == 8'h00 && q.w_strb[0] && !q.w_data[0]
                                  && !SRC_REQ[0] |=> !q.pend[0])
      else $error("software zero write did not clear pending flag");
   AST_LEVEL_GATE: assert property (s_per_take |-> CPU_IEN
                                    && lvl_of(q.lvl, int'(per_idx)) > CPU_IPL)
      else $error("maskable request accepted below processor level");
   AST_TIE_ORDER: assert property (s_per_take |-> tie_ok ##1 VEC_RD)
      else $error("equal-level tie not resolved by fixed priority");
   AST_WDT_FIRST: assert property (q.st == irq_seq_pkg::ST_IDLE && q.wdt_pend
                                   |=> VEC_RD && VEC_ADDR == WDT_VEC)
      else $error("watchdog did not take fixed priority");

endmodule : interrupt_request_sequencer

// ### test/vector_memory_model.sv
`timescale 1ns/1ns
module vector_memory_model (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Vector read request
   input  wire logic        rd,
   input  wire logic [31:0] addr,
   input  wire logic        slow,
   // Vector read answer
   output logic             valid,
   output logic [31:0]      data
);
   // ****************************************
   // Vector table answering one word per read
   // ****************************************
   logic [3:0] wait_q;

   // Between answers the data lines toggle, so a stale word never passes for a fresh one.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wait_q <= 4'h0;
         valid  <= 1'b0;
         data   <= 32'h5A5A_A5A5;
      end
      else if (valid)
      begin
         valid <= 1'b0;
         data  <= ~data;
      end
      else if (rd && (wait_q >= (slow ? 4'h5 : 4'h0)))
      begin
         wait_q <= 4'h0;
         valid  <= 1'b1;
         data   <= ~addr;
      end
      else
      begin
         wait_q <= rd ? wait_q + 4'h1 : 4'h0;
         data   <= ~data;
      end
   end
endmodule : vector_memory_model

// ### test/interrupt_request_sequencer_tb.sv
`timescale 1ns/1ns
module interrupt_request_sequencer_tb;
   // ****************************************
   // Signals
   // ****************************************
   localparam logic [31:0] TB    = 32'h0000_1000;
   localparam logic [31:0] WDT_V = 32'h0000_0F00;
   localparam logic [31:0] BRK_V = 32'h0000_0E00;
   localparam logic [7:0]  PER_N = 8'h10;
   logic        CLK = 1'b0, RST = 1'b1, WDT_REQ = 1'b0, SWI_REQ = 1'b0, BRK_EXEC = 1'b0;
   logic        CPU_RET = 1'b0, CPU_IEN = 1'b0, slow = 1'b0;
   logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
   logic [7:0]  SRC_REQ = 8'h00, SWI_NUM = 8'h00, BRK_BYTE = 8'h00, AWADDR = 8'h00;
   logic [7:0]  ARADDR = 8'h00;
   logic [2:0]  CPU_IPL = 3'h0;
   logic [3:0]  WSTRB = 4'hF;
   logic [31:0] WDATA = 32'h0, VEC_DATA, VEC_ADDR, JUMP_ADDR, RDATA, rdv;
   logic        VEC_RD, VEC_VALID, JUMP, STACK_SEL, BUSY, IRQ;
   logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
   logic [1:0]  BRESP, RRESP, rs;
   int          fail_count = 0, check_count = 0;

   initial
   begin
      forever #50 CLK = ~CLK;
   end

   interrupt_request_sequencer #(.NSRC (8), .PER_NUM (PER_N), .WDT_VEC (WDT_V),
      .BRK_VEC (BRK_V)) i_dut (
      .CLK (CLK), .RST (RST), .SRC_REQ (SRC_REQ), .WDT_REQ (WDT_REQ), .SWI_REQ (SWI_REQ),
      .SWI_NUM (SWI_NUM), .BRK_EXEC (BRK_EXEC), .BRK_BYTE (BRK_BYTE), .CPU_RET (CPU_RET),
      .CPU_IPL (CPU_IPL), .CPU_IEN (CPU_IEN), .VEC_RD (VEC_RD), .VEC_ADDR (VEC_ADDR),
      .VEC_VALID (VEC_VALID), .VEC_DATA (VEC_DATA), .JUMP (JUMP), .JUMP_ADDR (JUMP_ADDR),
      .STACK_SEL (STACK_SEL), .BUSY (BUSY), .IRQ (IRQ), .AWADDR (AWADDR),
      .AWVALID (AWVALID), .AWREADY (AWREADY), .WDATA (WDATA), .WSTRB (WSTRB),
      .WVALID (WVALID), .WREADY (WREADY), .BRESP (BRESP), .BVALID (BVALID),
      .BREADY (BREADY), .ARADDR (ARADDR), .ARVALID (ARVALID), .ARREADY (ARREADY),
      .RDATA (RDATA), .RRESP (RRESP), .RVALID (RVALID), .RREADY (RREADY));

   vector_memory_model i_vec (.clk (CLK), .rst (RST), .rd (VEC_RD), .addr (VEC_ADDR),
      .slow (slow), .valid (VEC_VALID), .data (VEC_DATA));

   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic results;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : results

   // Ready is registered, so its value at the falling edge is what the next rising edge sees.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w, b = 1'b0;
      int   n = 0;
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      while (!b && n < 50)
      begin
         @(negedge CLK);
         aw = AWVALID && AWREADY;
         w = WVALID && WREADY;
         b = BVALID && BREADY;
         rs = BRESP;
         @(posedge CLK);
         if (aw) AWVALID <= 1'b0;
         if (w) WVALID <= 1'b0;
         if (b) BREADY <= 1'b0;
         n++;
      end
      chk("bvalid", 32'h1, {31'h0, b});
   endtask : wr

   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic ar, r = 1'b0;
      int   n = 0;
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      while (!r && n < 50)
      begin
         @(negedge CLK);
         ar = ARVALID && ARREADY;
         r = RVALID && RREADY;
         rdv = RDATA;
         rs = RRESP;
         @(posedge CLK);
         if (ar) ARVALID <= 1'b0;
         if (r) RREADY <= 1'b0;
         n++;
      end
      chk(nm, e, rdv);
   endtask : rd_chk

   task automatic seq(input logic [31:0] va);
      int n = 0;
      @(negedge CLK);
      while (VEC_RD !== 1'b1 && n < 20)
      begin
         @(negedge CLK);
         n++;
      end
      chk("vec_addr", va, VEC_ADDR);
      while (JUMP !== 1'b1 && n < 40)
      begin
         @(negedge CLK);
         n++;
      end
      chk("jump_addr", ~va, JUMP_ADDR);
      @(posedge CLK);
   endtask : seq

   task automatic stk(input logic e);
      @(negedge CLK);
      chk("stack_sel", {31'h0, e}, {31'h0, STACK_SEL});
      @(posedge CLK);
   endtask : stk

   task automatic ret(input logic e);
      CPU_RET <= 1'b1;
      @(posedge CLK);
      CPU_RET <= 1'b0;
      @(posedge CLK);
      stk(e);
   endtask : ret

   task automatic swi(input logic [7:0] num);
      SWI_NUM <= num;
      SWI_REQ <= 1'b1;
      @(posedge CLK);
      SWI_REQ <= 1'b0;
      seq(TB + {22'h0, num, 2'h0});
   endtask : swi

   task automatic break_instruction(input logic [7:0] b, input logic [31:0] va);
      BRK_BYTE <= b;
      BRK_EXEC <= 1'b1;
      @(posedge CLK);
      BRK_EXEC <= 1'b0;
      seq(va);
   endtask : break_instruction

   task automatic idle_chk;
      repeat (3) @(negedge CLK);
      chk("busy", 32'h0, {31'h0, BUSY});
      @(posedge CLK);
   endtask : idle_chk

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      repeat (5000) @(posedge CLK);
      fail_count++;
      results();
   end

   initial
   begin
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      rd_chk("tbase", irq_seq_pkg::ADDR_TBASE, irq_seq_pkg::TBASE_RST);
      wr(irq_seq_pkg::ADDR_TBASE, TB);
      wr(irq_seq_pkg::ADDR_STATE, 32'h0000_0001);
      stk(1'b1);
      swi(8'h7F);
      stk(1'b0);
      ret(1'b1);
      swi(8'h80);
      stk(1'b1);
      ret(1'b1);
      slow <= 1'b1;
      break_instruction(8'hFF, TB);
      break_instruction(8'hFE, BRK_V);
      slow <= 1'b0;
      wr(irq_seq_pkg::ADDR_LEVEL, 32'h0000_0820);
      SRC_REQ <= 8'h0A;
      @(posedge CLK);
      SRC_REQ <= 8'h00;
      idle_chk();
      CPU_IEN <= 1'b1;
      CPU_IPL <= 3'h4;
      idle_chk();
      rd_chk("pend", irq_seq_pkg::ADDR_PEND, 32'h0000_000A);
      CPU_IPL <= 3'h3;
      @(posedge CLK);
      seq(TB + 4 * (PER_N + 1));
      seq(TB + 4 * (PER_N + 3));
      rd_chk("pend", irq_seq_pkg::ADDR_PEND, 32'h0);
      SRC_REQ <= 8'h02;
      WDT_REQ <= 1'b1;
      @(posedge CLK);
      SRC_REQ <= 8'h00;
      WDT_REQ <= 1'b0;
      seq(WDT_V);
      seq(TB + 4 * (PER_N + 1));
      SRC_REQ <= 8'h04;
      @(posedge CLK);
      SRC_REQ <= 8'h00;
      rd_chk("pend", irq_seq_pkg::ADDR_PEND, 32'h0000_0004);
      wr(irq_seq_pkg::ADDR_PEND, 32'h0);
      rd_chk("pend", irq_seq_pkg::ADDR_PEND, 32'h0);
      chk("irq", 32'h0, {31'h0, IRQ});
      wr(irq_seq_pkg::ADDR_STAT, 32'h0000_000F);
      rd_chk("stat", irq_seq_pkg::ADDR_STAT, 32'h0);
      wr(irq_seq_pkg::ADDR_MASK, 32'h0000_0001);
      swi(8'h82);
      rd_chk("stat", irq_seq_pkg::ADDR_STAT, 32'h0000_0003);
      chk("irq", 32'h1, {31'h0, IRQ});
      wr(irq_seq_pkg::ADDR_STAT, 32'h0000_0001);
      chk("irq", 32'h0, {31'h0, IRQ});
      rd_chk("unmapped", 8'h18, 32'h0);
      chk("rresp", {30'h0, irq_seq_pkg::RESP_SLVERR}, {30'h0, rs});
      wr(8'h1C, 32'h0000_0001);
      chk("bresp", {30'h0, irq_seq_pkg::RESP_SLVERR}, {30'h0, rs});
      results();
   end
endmodule : interrupt_request_sequencer_tb
